/* hw/owm_pkg.sv */
package owm_pkg;

  // Address map
  localparam logic [7:0] SCR_FIRST = 8'h00;
  localparam logic [7:0] SCR_LAST = 8'h4b;
  localparam logic [7:0] REG_FIRST = 8'h60;
  localparam logic [7:0] VOL_LAST = 8'h6f;
  localparam logic [7:0] ADDR_CMD = 8'h60;
  localparam logic [7:0] ADDR_STATUS = 8'h61;
  localparam logic [7:0] ADDR_RDATA = 8'h62;
  localparam logic [7:0] ADDR_MCFG = 8'h67;
  localparam logic [7:0] ADDR_TRSTL = 8'h68;
  localparam logic [7:0] ADDR_PRESENCE_SAMPLE_TIME = 8'h69;
  localparam logic [7:0] ADDR_TW0L = 8'h6a;
  localparam logic [7:0] ADDR_TREC = 8'h6b;
  localparam logic [7:0] ADDR_RWPU = 8'h6c;
  localparam logic [7:0] ADDR_TW1L = 8'h6d;
  localparam logic [7:0] ADDR_FACT = 8'h70;
  localparam logic [7:0] ADDR_PERS = 8'h73;
  localparam logic [7:0] PG0_FIRST = 8'h80;
  localparam logic [7:0] PG1_LAST = 8'hbf;
  localparam int SCR_BYTES = 76;
  localparam int PAGE_BYTES = 64;

  // Value returned for reserved, write-only and unmapped reads
  localparam logic [7:0] RSVD_RDATA = 8'hff;

  // Status bit positions
  localparam int ST_DIR = 7;
  localparam int ST_TSB = 6;
  localparam int ST_SBR = 5;
  localparam int ST_RST = 4;
  localparam int ST_LL = 3;
  localparam int ST_SD = 2;
  localparam int ST_PPD = 1;
  localparam int ST_BUSY = 0;

  // Reset values
  localparam logic [7:0] MCFG_RST = 8'h00;
  localparam logic [7:0] TRSTL_RST = 8'h06;
  localparam logic [7:0] PRESENCE_SAMPLE_TIME_RST = 8'h06;
  localparam logic [7:0] TW0L_RST = 8'h06;
  localparam logic [7:0] TREC_RST = 8'h01;
  localparam logic [7:0] RWPU_RST = 8'h06;
  localparam logic [7:0] TW1L_RST = 8'h03;

  // Identity bytes, values arbitrary
  localparam logic [7:0] FACTORY_ID = 8'h5a;
  localparam logic [7:0] PERSONALITY = 8'ha5;

  // Command codes
  localparam logic [7:0] CMD_DEV_RST = 8'h01;
  localparam logic [7:0] CMD_BUS_RST = 8'h02;
  localparam logic [7:0] CMD_BIT = 8'h03;
  localparam logic [7:0] CMD_WBYTE = 8'h04;
  localparam logic [7:0] CMD_RBYTE = 8'h05;
  localparam logic [7:0] CMD_TRIP = 8'h06;

  // Operations handed to the line timing engine
  typedef enum logic [2:0] {
    OWM_OP_NONE = 3'b000,
    OWM_OP_RESET = 3'b001,
    OWM_OP_BIT = 3'b010,
    OWM_OP_WBYTE = 3'b011,
    OWM_OP_RBYTE = 3'b100,
    OWM_OP_TRIP = 3'b101
  } owm_op_e;

  // Command intake states
  typedef enum logic [1:0] {
    OWM_ST_IDLE = 2'b00,
    OWM_ST_PARAM = 2'b01,
    OWM_ST_BUSY = 2'b10
  } owm_state_e;

endpackage

/* hw/owm_regs.sv */
`timescale 1ns/1ps
// How it works
// - Scratchpad 00h-4Bh is read/write storage
// - Registers from 60h; 00h-6Fh volatile
// - 70h factory, 73h personality, pages 80h/A0h
// - Port timing defaults load at power-on
// - Command register is write-only, never read
// - Status/read data RO, config RW, ident RO
// - Command code picks operation and read pointer
// - Line and reset commands point at status
// - Bit 7: triplet direction, triplet only
// - Bit 6: triplet second bit sample
// - Bit 5: single bit or first triplet bit
// - Sending a zero bit gives zero result
// - Bit 4 set by reset, cleared by config write
// - Bit 3 samples line at read acknowledge
// - Bit 2 short flag updated per bus reset
// - Bit 1 presence flag updated per bus reset
// - Bit 0 busy during line communication
// - Read byte result lands at 62h
// - Master config guarded by complement nibble
module owm_regs
  import owm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Sleep pin, active low, asynchronous
  input wire logic sleep_request_n_i,
  // Host byte port from the serial slave front end
  input wire logic hst_ptr_vld_i,
  input wire logic [7:0] hst_ptr_i,
  input wire logic hst_wr_i,
  input wire logic [7:0] hst_wdata_i,
  input wire logic hst_rd_ack_i,
  input wire logic hst_rd_i,
  output logic [7:0] hst_rdata_o,
  output logic [7:0] hst_ptr_o,
  // Line timing engine
  output logic eng_req_o,
  output owm_op_e eng_op_o,
  output logic [7:0] eng_data_o,
  input wire logic eng_done_i,
  input wire logic eng_bit1_i,
  input wire logic eng_bit2_i,
  input wire logic eng_dir_i,
  input wire logic [7:0] eng_rbyte_i,
  input wire logic eng_short_i,
  input wire logic eng_presence_i,
  // Live line level, asynchronous
  input wire logic line_i,
  // Configuration to the engine
  output logic [3:0] mcfg_o,
  output logic [7:0] trstl_o,
  output logic [7:0] presence_sample_time_o,
  output logic [7:0] tw0l_o,
  output logic [7:0] trec_o,
  output logic [7:0] rwpu_o,
  output logic [7:0] tw1l_o
);

  // True where the address holds volatile scratchpad storage
  function automatic logic in_scr(input logic [7:0] a);
    return a <= SCR_LAST;
  endfunction

  // True inside either user page
  function automatic logic in_page(input logic [7:0] a);
    return (a >= PG0_FIRST) && (a <= PG1_LAST);
  endfunction

  // Synchronisers; first stages read only by second stages
  logic slp_s1_q, slp_s2_q, slp_s3_q;
  logic line_s1_q, line_s2_q;

  // Storage
  logic [7:0] scr_q [SCR_BYTES]; // Scratchpad
  logic [7:0] page_q [PAGE_BYTES]; // User pages
  logic [7:0] ptr_q; // Host read/write pointer
  logic [7:0] rdata_q; // Registered read data
  logic [3:0] mcfg_q; // Master config low nibble
  logic [7:0] trstl_q, presence_sample_time_q, tw0l_q, trec_q, rwpu_q, tw1l_q;
  logic [7:0] rbyte_q; // Last byte read from the line
  logic dir_q, tsb_q, sbr_q, rst_q, ll_q, sd_q, ppd_q, busy_q;

  // Command intake
  owm_state_e state_q;
  owm_op_e op_q;
  logic [7:0] param_q;
  logic req_q;
  logic sent_bit_q; // Bit 7 of the last parameter byte, the value sent by a single-bit command

  // Device reset: power-on, sleep pin pulse or reset command
  logic slp_fall;
  logic cmd_dev_rst;
  logic dev_rst;
  logic cmd_wr;
  logic [7:0] cmd_code;
  logic mcfg_ok;

  assign slp_fall = slp_s3_q && !slp_s2_q;
  assign cmd_wr = hst_wr_i && (ptr_q == ADDR_CMD);
  assign cmd_code = hst_wdata_i;
  // Reset command taken only as a code byte; a parameter of 01h must not reset
  assign cmd_dev_rst = cmd_wr && (state_q == OWM_ST_IDLE) && (cmd_code == CMD_DEV_RST);
  assign dev_rst = slp_fall || cmd_dev_rst;
  // Complement check on the two nibbles
  assign mcfg_ok = hst_wdata_i[7:4] == ~hst_wdata_i[3:0];

  // Two-stage synchronisers plus an edge stage on the sleep pin
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      slp_s1_q <= 1'b1;
      slp_s2_q <= 1'b1;
      slp_s3_q <= 1'b1;
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end else begin
      slp_s1_q <= sleep_request_n_i;
      slp_s2_q <= slp_s1_q;
      slp_s3_q <= slp_s2_q;
      line_s1_q <= line_i;
      line_s2_q <= line_s1_q;
    end
  end

  // Command intake: code, optional parameter, then wait for the engine
  always_ff @(posedge clk_i) begin
    if (srst_i || dev_rst) begin
      state_q <= OWM_ST_IDLE;
      op_q <= OWM_OP_NONE;
      param_q <= 8'h00;
      req_q <= 1'b0;
      sent_bit_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      unique case (state_q)
        OWM_ST_IDLE: begin
          if (cmd_wr) begin
            // Unknown codes are dropped without effect
            if (cmd_code == CMD_BUS_RST) begin
              op_q <= OWM_OP_RESET;
              req_q <= 1'b1;
              state_q <= OWM_ST_BUSY;
            end else if (cmd_code == CMD_RBYTE) begin
              op_q <= OWM_OP_RBYTE;
              req_q <= 1'b1;
              state_q <= OWM_ST_BUSY;
            end else if (cmd_code == CMD_BIT) begin
              op_q <= OWM_OP_BIT;
              state_q <= OWM_ST_PARAM;
            end else if (cmd_code == CMD_WBYTE) begin
              op_q <= OWM_OP_WBYTE;
              state_q <= OWM_ST_PARAM;
            end else if (cmd_code == CMD_TRIP) begin
              op_q <= OWM_OP_TRIP;
              state_q <= OWM_ST_PARAM;
            end
          end
        end
        OWM_ST_PARAM: begin
          // Parameter byte follows the code at the same address
          if (cmd_wr) begin
            param_q <= hst_wdata_i;
            sent_bit_q <= hst_wdata_i[7];
            req_q <= 1'b1;
            state_q <= OWM_ST_BUSY;
          end
        end
        OWM_ST_BUSY: begin
          // Further command bytes are ignored until done
          if (eng_done_i) begin
            state_q <= OWM_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Host pointer: set by address phase, moved by commands, steps on access
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ptr_q <= ADDR_STATUS;
    end else if (hst_ptr_vld_i) begin
      ptr_q <= hst_ptr_i;
    end else if (cmd_wr && (state_q != OWM_ST_BUSY)) begin
      // Command bytes hold the pointer at the command register until the
      // last byte, then park it at status for cheap polling
      if (cmd_code == CMD_DEV_RST || cmd_code == CMD_BUS_RST || cmd_code == CMD_RBYTE ||
          state_q == OWM_ST_PARAM) begin
        ptr_q <= ADDR_STATUS;
      end
    end else if (hst_wr_i || hst_rd_i) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Engine request, one pulse per command
  assign eng_req_o = req_q;
  assign eng_op_o = op_q;
  assign eng_data_o = param_q;

  // Scratchpad and pages; writes elsewhere fall through unstored
  always_ff @(posedge clk_i) begin
    if (hst_wr_i && !hst_ptr_vld_i) begin
      if (in_scr(ptr_q)) begin
        scr_q[ptr_q[6:0]] <= hst_wdata_i;
      end else if (in_page(ptr_q)) begin
        page_q[6'(ptr_q - PG0_FIRST)] <= hst_wdata_i;
      end
    end
  end

  // Port timing registers; defaults on power-on and sleep reset
  always_ff @(posedge clk_i) begin
    if (srst_i || slp_fall) begin
      trstl_q <= TRSTL_RST;
      presence_sample_time_q <= PRESENCE_SAMPLE_TIME_RST;
      tw0l_q <= TW0L_RST;
      trec_q <= TREC_RST;
      rwpu_q <= RWPU_RST;
      tw1l_q <= TW1L_RST;
    end else if (hst_wr_i && !hst_ptr_vld_i) begin
      unique case (ptr_q)
        ADDR_TRSTL: trstl_q <= hst_wdata_i;
        ADDR_PRESENCE_SAMPLE_TIME: presence_sample_time_q <= hst_wdata_i;
        ADDR_TW0L: tw0l_q <= hst_wdata_i;
        ADDR_TREC: trec_q <= hst_wdata_i;
        ADDR_RWPU: rwpu_q <= hst_wdata_i;
        ADDR_TW1L: tw1l_q <= hst_wdata_i;
        default: ; // Read-only and reserved writes ignored
      endcase
    end
  end

  // Master configuration, only the guarded low nibble is kept
  always_ff @(posedge clk_i) begin
    if (srst_i || dev_rst) begin
      mcfg_q <= MCFG_RST[3:0];
    end else if (hst_wr_i && !hst_ptr_vld_i && ptr_q == ADDR_MCFG && mcfg_ok) begin
      mcfg_q <= hst_wdata_i[3:0];
    end
  end

  // Reset history: set wins over the config-write clear
  always_ff @(posedge clk_i) begin
    if (srst_i || dev_rst) begin
      rst_q <= 1'b1;
    end else if (hst_wr_i && !hst_ptr_vld_i && ptr_q == ADDR_MCFG && mcfg_ok) begin
      rst_q <= 1'b0;
    end
  end

  // Busy flag spans request to engine completion
  always_ff @(posedge clk_i) begin
    if (srst_i || dev_rst) begin
      busy_q <= 1'b0;
    end else if (req_q) begin
      busy_q <= 1'b1;
    end else if (eng_done_i) begin
      busy_q <= 1'b0;
    end
  end

  // Line results captured at engine completion
  always_ff @(posedge clk_i) begin
    if (srst_i || dev_rst) begin
      dir_q <= 1'b0;
      tsb_q <= 1'b0;
      sbr_q <= 1'b0;
      sd_q <= 1'b0;
      ppd_q <= 1'b0;
      rbyte_q <= 8'h00;
    end else if (eng_done_i && state_q == OWM_ST_BUSY) begin
      unique case (op_q)
        OWM_OP_TRIP: begin
          dir_q <= eng_dir_i;
          tsb_q <= eng_bit2_i;
          sbr_q <= eng_bit1_i;
        end
        OWM_OP_BIT: begin
          // A written zero keeps the line low, so its result is zero
          sbr_q <= eng_bit1_i && sent_bit_q;
        end
        OWM_OP_RESET: begin
          sd_q <= eng_short_i;
          // A shorted line can not carry a presence pulse
          ppd_q <= eng_presence_i && !eng_short_i;
        end
        OWM_OP_RBYTE: rbyte_q <= eng_rbyte_i;
        default: ;
      endcase
    end
  end

  // Live level sampled at the read acknowledge, pointer at status
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ll_q <= 1'b0;
    end else if (hst_rd_ack_i && ptr_q == ADDR_STATUS) begin
      ll_q <= line_s2_q;
    end
  end

  // Read data follows the pointer one cycle later
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= RSVD_RDATA;
    end else if (in_scr(ptr_q)) begin
      rdata_q <= scr_q[ptr_q[6:0]];
    end else if (in_page(ptr_q)) begin
      rdata_q <= page_q[6'(ptr_q - PG0_FIRST)];
    end else begin
      unique case (ptr_q)
        ADDR_STATUS: rdata_q <= {dir_q, tsb_q, sbr_q, rst_q, ll_q, sd_q, ppd_q, busy_q};
        ADDR_RDATA: rdata_q <= rbyte_q;
        ADDR_MCFG: rdata_q <= {4'h0, mcfg_q};
        ADDR_TRSTL: rdata_q <= trstl_q;
        ADDR_PRESENCE_SAMPLE_TIME: rdata_q <= presence_sample_time_q;
        ADDR_TW0L: rdata_q <= tw0l_q;
        ADDR_TREC: rdata_q <= trec_q;
        ADDR_RWPU: rdata_q <= rwpu_q;
        ADDR_TW1L: rdata_q <= tw1l_q;
        ADDR_FACT: rdata_q <= FACTORY_ID;
        ADDR_PERS: rdata_q <= PERSONALITY;
        default: rdata_q <= RSVD_RDATA; // Command register too
      endcase
    end
  end

  // Outputs
  assign hst_rdata_o = rdata_q;
  assign hst_ptr_o = ptr_q;
  assign mcfg_o = mcfg_q;
  assign trstl_o = trstl_q;
  assign presence_sample_time_o = presence_sample_time_q;
  assign tw0l_o = tw0l_q;
  assign trec_o = trec_q;
  assign rwpu_o = rwpu_q;
  assign tw1l_o = tw1l_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_cmd_no_read: assert property (
    ptr_q == ADDR_CMD |=> rdata_q == RSVD_RDATA)
    else $error("command register read back content");

  a_status_park: assert property (
    cmd_wr && state_q == OWM_ST_PARAM && !hst_ptr_vld_i |=> ptr_q == ADDR_STATUS)
    else $error("pointer not parked at status after command");

  a_busy_span: assert property (
    (req_q || (busy_q && !eng_done_i)) && !dev_rst |=> busy_q)
    else $error("busy flag did not span the command");

  a_busy_clear: assert property (
    busy_q && eng_done_i && !req_q && !dev_rst |=> !busy_q)
    else $error("busy not cleared on completion");

  a_dir_stable: assert property (
    !(eng_done_i && op_q == OWM_OP_TRIP) && !dev_rst |=> $stable(dir_q) && $stable(tsb_q))
    else $error("triplet flags moved without a triplet");

  a_zero_bit: assert property (
    state_q == OWM_ST_BUSY && op_q == OWM_OP_BIT && eng_done_i && !sent_bit_q && !dev_rst
      |=> !sbr_q)
    else $error("single bit zero gave nonzero result");

  a_rst_clear: assert property (
    hst_wr_i && !hst_ptr_vld_i && ptr_q == ADDR_MCFG && mcfg_ok && !dev_rst |=> !rst_q)
    else $error("reset flag not cleared by config write");

  a_rst_set: assert property (
    dev_rst |=> rst_q && mcfg_q == 4'h0)
    else $error("device reset did not mark status");

  a_mcfg_guard: assert property (
    hst_wr_i && ptr_q == ADDR_MCFG && !mcfg_ok && !dev_rst |=> $stable(mcfg_q))
    else $error("unguarded config write accepted");

  a_short_ppd: assert property (
    state_q == OWM_ST_BUSY && op_q == OWM_OP_RESET && eng_done_i && eng_short_i && !dev_rst
      |=> sd_q && !ppd_q)
    else $error("short did not clear presence");

  a_rbyte_store: assert property (
    state_q == OWM_ST_BUSY && op_q == OWM_OP_RBYTE && eng_done_i && !dev_rst
      |=> rbyte_q == $past(eng_rbyte_i))
    else $error("read byte not stored");

  c_bus_reset: cover property (req_q && op_q == OWM_OP_RESET ##[1:50] eng_done_i);
  c_triplet: cover property (req_q && op_q == OWM_OP_TRIP ##[1:50] eng_done_i);
  c_read_fetch: cover property (eng_done_i && op_q == OWM_OP_RBYTE ##[1:20] hst_ptr_vld_i);
  c_sleep: cover property (slp_fall);

endmodule

/* tb/owm_eng_model.sv */
`timescale 1ns/1ps
// Behavioural line timing engine on the far side of the register block
module owm_eng_model
  import owm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Request from the register block
  input wire logic req_i,
  // Results chosen by the bench: {dir, second, first, short, presence, byte}
  input wire logic [12:0] knob_i,
  input wire logic [4:0] lag_i,
  // Completion and results back to the register block
  output logic done_o,
  output logic dir_o,
  output logic bit2_o,
  output logic bit1_o,
  output logic short_o,
  output logic presence_o,
  output logic [7:0] rbyte_o
);
  logic run_q; // Operation in flight
  logic [4:0] cnt_q; // Cycles left before completion
  logic [12:0] res; // Result lines as presented

  // Slot timer, a fresh lag for every request
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_q <= 1'b0;
      cnt_q <= 5'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (req_i) begin
        run_q <= 1'b1;
        cnt_q <= lag_i;
      end else if (run_q && cnt_q == 5'h00) begin
        run_q <= 1'b0;
        done_o <= 1'b1;
      end else if (run_q) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  // Raw samples only valid with done; scrambled otherwise so stale reads show
  assign res = done_o ? knob_i : ~knob_i;
  assign {dir_o, bit2_o, bit1_o, short_o, presence_o, rbyte_o} = res;
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import owm_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic sleep_request_n_i = 1'b1;
  logic hst_ptr_vld_i = 1'b0;
  logic [7:0] hst_ptr_i = 8'h00;
  logic hst_wr_i = 1'b0;
  logic [7:0] hst_wdata_i = 8'h00;
  logic hst_rd_ack_i = 1'b0;
  logic hst_rd_i = 1'b0;
  logic line_i = 1'b1;
  logic [7:0] hst_rdata_o, hst_ptr_o, eng_data_o, eng_rbyte_i;
  logic eng_req_o, eng_done_i, eng_bit1_i, eng_bit2_i, eng_dir_i, eng_short_i, eng_presence_i;
  owm_op_e eng_op_o;
  logic [3:0] mcfg_o, m;
  logic [7:0] trstl_o, presence_sample_time_o, tw0l_o, trec_o, rwpu_o, tw1l_o;
  logic [12:0] knob = 13'h0000; // Engine results for the next command
  logic [4:0] lag = 5'h05; // Engine completion delay
  int bad_count = 0;
  int comparisons = 0;
  logic [7:0] exp_st, a, d, code, tim;
  // Fixed map entries and what they must read after reset
  logic [7:0] map_a [16] = '{ADDR_CMD, ADDR_MCFG, ADDR_TRSTL, ADDR_PRESENCE_SAMPLE_TIME, ADDR_TW0L, ADDR_TREC,
    ADDR_RWPU, ADDR_TW1L, ADDR_FACT, ADDR_PERS, 8'h4c, 8'h5f, 8'h66, 8'h6e, 8'h74, 8'hc0};
  logic [7:0] map_e [16] = '{RSVD_RDATA, MCFG_RST, TRSTL_RST, PRESENCE_SAMPLE_TIME_RST, TW0L_RST, TREC_RST,
    RWPU_RST, TW1L_RST, FACTORY_ID, PERSONALITY, RSVD_RDATA, RSVD_RDATA, RSVD_RDATA,
    RSVD_RDATA, RSVD_RDATA, RSVD_RDATA};

  owm_regs DUT (.clk_i(clk_i), .srst_i(srst_i), .sleep_request_n_i(sleep_request_n_i),
    .hst_ptr_vld_i(hst_ptr_vld_i), .hst_ptr_i(hst_ptr_i), .hst_wr_i(hst_wr_i),
    .hst_wdata_i(hst_wdata_i), .hst_rd_ack_i(hst_rd_ack_i), .hst_rd_i(hst_rd_i),
    .hst_rdata_o(hst_rdata_o), .hst_ptr_o(hst_ptr_o), .eng_req_o(eng_req_o),
    .eng_op_o(eng_op_o), .eng_data_o(eng_data_o), .eng_done_i(eng_done_i),
    .eng_bit1_i(eng_bit1_i), .eng_bit2_i(eng_bit2_i), .eng_dir_i(eng_dir_i),
    .eng_rbyte_i(eng_rbyte_i), .eng_short_i(eng_short_i), .eng_presence_i(eng_presence_i),
    .line_i(line_i), .mcfg_o(mcfg_o), .trstl_o(trstl_o), .presence_sample_time_o(presence_sample_time_o), .tw0l_o(tw0l_o),
    .trec_o(trec_o), .rwpu_o(rwpu_o), .tw1l_o(tw1l_o));

  owm_eng_model u_eng (.clk_i(clk_i), .srst_i(srst_i), .req_i(eng_req_o), .knob_i(knob),
    .lag_i(lag), .done_o(eng_done_i), .dir_o(eng_dir_i), .bit2_o(eng_bit2_i),
    .bit1_o(eng_bit1_i), .short_o(eng_short_i), .presence_o(eng_presence_i),
    .rbyte_o(eng_rbyte_i));

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Move just past a rising edge so the bench never races the design
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One host strobe: 0 pointer, 1 write, 2 read acknowledge, 3 byte taken
  task automatic strobe(input int k, input logic [7:0] v);
    tick(1);
    hst_ptr_i = v;
    hst_wdata_i = v;
    case (k)
      0: hst_ptr_vld_i = 1'b1;
      1: hst_wr_i = 1'b1;
      2: hst_rd_ack_i = 1'b1;
      default: hst_rd_i = 1'b1;
    endcase
    tick(1);
    {hst_ptr_vld_i, hst_wr_i, hst_rd_ack_i, hst_rd_i} = 4'h0;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Point, let the read data register settle, compare
  task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
    strobe(0, adr);
    tick(1);
    chk(hst_rdata_o, exp);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] v);
    strobe(0, adr);
    strobe(1, v);
  endtask

  // Status expected once a command has finished
  function automatic logic [7:0] next_st(input logic [7:0] s, input logic [7:0] c,
                                         input logic [7:0] p, input logic [12:0] k);
    logic [7:0] r;
    r = s;
    r[ST_BUSY] = 1'b0;
    case (c)
      CMD_BUS_RST: begin
        r[ST_SD] = k[9];
        r[ST_PPD] = k[8] & ~k[9];
      end
      CMD_BIT: r[ST_SBR] = k[10] & p[7];
      CMD_TRIP: r[7:5] = k[12:10];
      default: r = r;
    endcase
    return r;
  endfunction

  // Code plus optional parameter, then poll busy like a host would
  task automatic run_cmd(input logic [7:0] c, input logic [7:0] p);
    int n;
    knob = 13'($urandom);
    lag = 5'($urandom_range(5, 25));
    strobe(0, ADDR_CMD);
    strobe(1, c);
    if (c inside {CMD_BIT, CMD_WBYTE, CMD_TRIP}) begin
      strobe(1, p);
      chk(eng_data_o, p);
    end
    chk(8'(eng_req_o), 8'h01);
    tick(3);
    chk(8'(eng_req_o), 8'h00);
    chk(hst_ptr_o, ADDR_STATUS);
    chk(8'(eng_op_o), c - 8'h01);
    chk(8'(hst_rdata_o[ST_BUSY]), 8'h01);
    n = 0;
    while (hst_rdata_o[ST_BUSY] !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    // A busy flag that never drops is a failure in its own right
    if (n == 100) begin
      bad_count++;
    end
    exp_st = next_st(exp_st, c, p, knob);
    chk(hst_rdata_o, exp_st);
    if (c == CMD_RBYTE) begin
      rdchk(ADDR_RDATA, knob[7:0]);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(43));
    tick(16);
    srst_i = 1'b0;
    exp_st = 8'h10;
    rdchk(ADDR_STATUS, exp_st);
    // Defaults, identity, command and reserved reads, then attempted overwrites
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 16; i++) begin
        rdchk(map_a[i], map_e[i]);
      end
      for (int i = 8; i < 16; i++) begin
        wr(map_a[i], ~map_e[i]);
      end
      wr(ADDR_STATUS, 8'h00);
      wr(ADDR_RDATA, 8'h5c);
    end
    rdchk(ADDR_STATUS, exp_st);
    // Scratchpad and user pages hold random data, top two addresses of each first
    for (int i = 0; i < 12; i++) begin
      a = (i < 4) ? ((i % 2) ? SCR_LAST : PG1_LAST) - 8'(i / 2) : 8'($urandom_range(0, 75));
      if (i >= 4 && i % 2) a = PG0_FIRST + 8'($urandom_range(0, 63));
      d = 8'($urandom);
      wr(a, d);
      rdchk(a, d);
    end
    // Config guard: bad complement refused, good one taken and clears reset flag
    wr(ADDR_MCFG, 8'h55);
    rdchk(ADDR_MCFG, MCFG_RST);
    rdchk(ADDR_STATUS, exp_st);
    m = 4'($urandom);
    wr(ADDR_MCFG, {~m, m});
    rdchk(ADDR_MCFG, {4'h0, m});
    chk({4'h0, mcfg_o}, {4'h0, m});
    exp_st[ST_RST] = 1'b0;
    rdchk(ADDR_STATUS, exp_st);
    tim = 8'($urandom);
    wr(ADDR_TRSTL, tim);
    rdchk(ADDR_TRSTL, tim);
    chk(trstl_o, tim);
    // Byte taken moves the pointer to the next timing register
    strobe(3, 8'h00);
    tick(1);
    chk(hst_rdata_o, PRESENCE_SAMPLE_TIME_RST);
    // Every line command once, then random ones
    for (int i = 0; i < 30; i++) begin
      code = (i < 5) ? CMD_BUS_RST + 8'(i) : CMD_BUS_RST + 8'($urandom_range(0, 4));
      run_cmd(code, (i == 1) ? 8'h00 : 8'($urandom));
    end
    // Live line level sampled at read acknowledge
    for (int i = 0; i < 4; i++) begin
      line_i = i[0];
      tick(4);
      strobe(0, ADDR_STATUS);
      strobe(2, 8'h00);
      tick(1);
      exp_st[ST_LL] = line_i;
      chk(hst_rdata_o, exp_st);
    end
    // Reset command: status and config back, timings kept
    wr(ADDR_CMD, CMD_DEV_RST);
    tick(4);
    chk(hst_ptr_o, ADDR_STATUS);
    // Line sample is only renewed at a read acknowledge, so it survives
    exp_st = 8'h10;
    exp_st[ST_LL] = line_i;
    chk(hst_rdata_o, exp_st);
    rdchk(ADDR_MCFG, MCFG_RST);
    chk({4'h0, mcfg_o}, MCFG_RST);
    rdchk(ADDR_TRSTL, tim);
    // Sleep pin pulse reloads timings too
    sleep_request_n_i = 1'b0;
    tick(6);
    sleep_request_n_i = 1'b1;
    tick(6);
    rdchk(ADDR_STATUS, exp_st);
    rdchk(ADDR_TRSTL, TRSTL_RST);
    chk(trstl_o, TRSTL_RST);
    chk(presence_sample_time_o, PRESENCE_SAMPLE_TIME_RST);
    chk(tw0l_o, TW0L_RST);
    chk(trec_o, TREC_RST);
    chk(rwpu_o, RWPU_RST);
    chk(tw1l_o, TW1L_RST);
    wrap_up();
  end
endmodule
